// *** ebcc_core_defines.vh ***
`ifndef EBCC_CORE_DEFINES_VH
`define EBCC_CORE_DEFINES_VH

// widths and fixed addresses
`define EBCC_PC_W 14
`define EBCC_ROM_TEST_BASE 14'h1fe0
`define EBCC_PC_RESET 14'h0000
`define EBCC_PTR_RESET 8'h00
`define EBCC_ONE 8'h01

// cycle step numbers inside one instruction
`define EBCC_S_FETCH 4'h0
`define EBCC_S_OPND 4'h1
`define EBCC_S_MEM 4'h2
`define EBCC_S_EXE 4'h3
`define EBCC_S_WB 4'h4

// instruction lengths in clock cycles
`define EBCC_CYC_SHORT 4'h4
`define EBCC_CYC_IO 4'h5
`define EBCC_CYC_IDX 4'h6
`define EBCC_CYC_RMW 4'h7
`define EBCC_CYC_RMWX 4'h8
`define EBCC_CYC_CALL 4'ha
`define EBCC_CYC_TABLE 4'he

// arithmetic block: opcodes 0x01..0x1d, three modes per group except MOVX, which has data and direct only
`define EBCC_ARITH_LO 8'h01
`define EBCC_ARITH_HI 8'h1d
`define EBCC_MODES 8'h03
`define EBCC_M_DATA 8'h00
`define EBCC_M_DIRECT 8'h01
`define EBCC_M_INDEX 8'h02
`define EBCC_G_ADD 8'h00
`define EBCC_G_ADC 8'h01
`define EBCC_G_SUB 8'h02
`define EBCC_G_SBB 8'h03
`define EBCC_G_OR 8'h04
`define EBCC_G_AND 8'h05
`define EBCC_G_XOR 8'h06
`define EBCC_G_CMP 8'h07
`define EBCC_G_MOVA 8'h08
`define EBCC_G_MOVX 8'h09

// single opcodes
`define EBCC_OP_HALT 8'h00
`define EBCC_OP_PAGE_ADVANCE_OP 8'h1f
`define EBCC_OP_NOP 8'h20
`define EBCC_OP_INCA 8'h21
`define EBCC_OP_INCX 8'h22
`define EBCC_OP_INCD 8'h23
`define EBCC_OP_INCI 8'h24
`define EBCC_OP_DECA 8'h25
`define EBCC_OP_DECX 8'h26
`define EBCC_OP_DECD 8'h27
`define EBCC_OP_DECI 8'h28
`define EBCC_OP_IO_READ_OP 8'h29
`define EBCC_OP_IOWR 8'h2a
`define EBCC_OP_POPA 8'h2b
`define EBCC_OP_POPX 8'h2c
`define EBCC_OP_PUSHA 8'h2d
`define EBCC_OP_PUSHX 8'h2e
`define EBCC_OP_SWAX 8'h2f
`define EBCC_OP_SWDSP 8'h30
`define EBCC_OP_STD 8'h31
`define EBCC_OP_STI 8'h32
`define EBCC_OP_ORD 8'h33
`define EBCC_OP_ORI 8'h34
`define EBCC_OP_ANDD 8'h35
`define EBCC_OP_ANDI 8'h36
`define EBCC_OP_XORD 8'h37
`define EBCC_OP_XORI 8'h38
`define EBCC_OP_IO_WRITE_INDEXED_OP 8'h39
`define EBCC_OP_CPL 8'h3a
`define EBCC_OP_ASL 8'h3b
`define EBCC_OP_ASR 8'h3c
`define EBCC_OP_RLC 8'h3d
`define EBCC_OP_RRC 8'h3e
`define EBCC_OP_RET 8'h3f
`define EBCC_OP_MOVAX 8'h40
`define EBCC_OP_MOVXA 8'h41
`define EBCC_OP_MOVPSP 8'h60
`define EBCC_OP_DI 8'h70
`define EBCC_OP_EI 8'h72
`define EBCC_OP_RETURN_FROM_INTERRUPT 8'h73

// high-nibble opcode families carrying a 12-bit address
`define EBCC_N_CALLHI 4'h5
`define EBCC_N_JMP 4'h8
`define EBCC_N_CALL 4'h9
`define EBCC_N_JZ 4'ha
`define EBCC_N_JNZ 4'hb
`define EBCC_N_JC 4'hc
`define EBCC_N_JNC 4'hd
`define EBCC_N_JUMP_PLUS_ACCUMULATOR 4'he
`define EBCC_N_INDEX 4'hf
`define EBCC_PAGE_LO 2'b00
`define EBCC_PAGE_HI 2'b01

`endif

// *** ebcc_core.v ***
// Function
// - decode opcodes, honour listed cycle counts
// - fetch one or two byte instructions
// - 14-bit counter cleared, fetch from zero
// - sequential fetch wraps within page
// - top 32 ROM bytes reserved
// - interrupt/call push counter and flags
// - return-from-interrupt restores flags, return doesn't
// - stack pointer resets zero, loaded, unreadable
// - acknowledge disables interrupts, two pushes
// - pop second then first, then enable
// - call adds two, return subtracts two
// - one 256-byte data RAM shared
// - push predecrements, pop postincrements
// - data pointer resets zero, wraps
// - opcode 30 swaps accumulator and pointer
// - immediate operand is second byte
// - direct operand read from RAM
// - indexed address is constant plus X
`timescale 1ns/10ps
`include "ebcc_core_defines.vh"

module ebcc_core (
  input wire clk,
  input wire rst,
  output wire [13:0] rom_addr,
  input wire [7:0] rom_data,
  output reg [7:0] ram_addr,
  output reg [7:0] ram_wdata,
  output reg ram_we,
  input wire [7:0] ram_rdata,
  output wire [7:0] io_addr,
  output wire [7:0] io_wdata,
  output wire io_we,
  output wire io_re,
  input wire [7:0] io_rdata,
  input wire int_req,
  input wire [13:0] int_vector,
  output wire int_ack,
  output wire int_enabled,
  output wire halted,
  output wire rom_test_area
);

  reg [13:0] pc_r;
  reg [7:0] a_r;
  reg [7:0] x_r;
  reg [7:0] psp_r;
  reg [7:0] dsp_r;
  reg [7:0] op_r;
  reg [7:0] arg_r;
  reg [7:0] mem_r;
  reg [7:0] res_r;
  reg [7:0] ret_hi_r;
  reg [13:0] vec_r;
  reg [3:0] cyc_r;
  reg c_r;
  reg z_r;
  reg ie_r;
  reg irq_r;
  reg halt_r;

  // the interrupt sequence after an acknowledge decodes as a no-op opcode
  wire [7:0] dop = irq_r ? `EBCC_OP_NOP : op_r;
  wire [3:0] nib = dop[7:4];
  wire arith = (dop >= `EBCC_ARITH_LO) && (dop <= `EBCC_ARITH_HI);
  wire [7:0] arel = dop - `EBCC_ARITH_LO;
  wire [7:0] grp = arel / `EBCC_MODES;
  wire [7:0] mode = arel % `EBCC_MODES;
  wire is_call = (nib == `EBCC_N_CALL) || (nib == `EBCC_N_CALLHI);
  wire is_ret = (dop == `EBCC_OP_RET) || (dop == `EBCC_OP_RETURN_FROM_INTERRUPT);
  wire is_push = (dop == `EBCC_OP_PUSHA) || (dop == `EBCC_OP_PUSHX);
  wire is_pop = (dop == `EBCC_OP_POPA) || (dop == `EBCC_OP_POPX);
  wire is_store = (dop == `EBCC_OP_STD) || (dop == `EBCC_OP_STI);
  wire is_rmw = (dop == `EBCC_OP_INCD) || (dop == `EBCC_OP_INCI) ||
    (dop == `EBCC_OP_DECD) || (dop == `EBCC_OP_DECI) ||
    ((dop >= `EBCC_OP_ORD) && (dop <= `EBCC_OP_XORI));
  wire is_idx = (arith && (mode == `EBCC_M_INDEX)) || (dop == `EBCC_OP_INCI) ||
    (dop == `EBCC_OP_DECI) || (dop == `EBCC_OP_STI) || (dop == `EBCC_OP_ORI) ||
    (dop == `EBCC_OP_ANDI) || (dop == `EBCC_OP_XORI) || (dop == `EBCC_OP_IO_WRITE_INDEXED_OP);
  wire rd_mem = (arith && (mode != `EBCC_M_DATA)) || is_rmw;
  wire two_byte = arith || is_rmw || is_store || dop[7] || (nib == `EBCC_N_CALLHI) ||
    ((dop >= `EBCC_OP_IO_READ_OP) && (dop <= `EBCC_OP_IOWR)) || (dop == `EBCC_OP_IO_WRITE_INDEXED_OP);
  // indexed sum kept at eight bits
  wire [7:0] ea = arg_r + (is_idx ? x_r : 8'h00);
  wire [13:0] tgt = {(nib == `EBCC_N_CALLHI) ? `EBCC_PAGE_HI : `EBCC_PAGE_LO, dop[3:0], arg_r};
  wire [13:0] tgt_acc = tgt + {6'h00, a_r};
  wire [7:0] opnd = (mode == `EBCC_M_DATA) ? arg_r : mem_r;
  wire [7:0] pc_lo_inc = pc_r[7:0] + `EBCC_ONE;
  wire [7:0] dsp_dec = dsp_r - `EBCC_ONE;

  // instruction length lookup
  reg [3:0] len;
  always @*
  begin
    len = `EBCC_CYC_SHORT;
    if (irq_r)
      len = `EBCC_CYC_CALL;
    else if (arith)
    begin
      if (grp >= `EBCC_G_MOVA)
        len = (mode == `EBCC_M_DATA) ? `EBCC_CYC_SHORT :
          (mode == `EBCC_M_DIRECT) ? `EBCC_CYC_IO : `EBCC_CYC_IDX;
      else if (grp == `EBCC_G_CMP)
        len = (mode == `EBCC_M_DATA) ? `EBCC_CYC_IO :
          (mode == `EBCC_M_DIRECT) ? `EBCC_CYC_RMW : `EBCC_CYC_RMWX;
      else
        len = (mode == `EBCC_M_DATA) ? `EBCC_CYC_SHORT :
          (mode == `EBCC_M_DIRECT) ? `EBCC_CYC_IDX : `EBCC_CYC_RMW;
    end
    else if (is_call)
      len = `EBCC_CYC_CALL;
    else if (nib == `EBCC_N_JUMP_PLUS_ACCUMULATOR)
      len = `EBCC_CYC_RMW;
    else if (nib == `EBCC_N_INDEX)
      len = `EBCC_CYC_TABLE;
    else if (dop[7])
      len = `EBCC_CYC_IO;
    else
      case (dop)
        `EBCC_OP_HALT, `EBCC_OP_INCD, `EBCC_OP_DECD, `EBCC_OP_ORD, `EBCC_OP_ANDD,
        `EBCC_OP_XORD: len = `EBCC_CYC_RMW;
        `EBCC_OP_INCI, `EBCC_OP_DECI, `EBCC_OP_ORI, `EBCC_OP_ANDI, `EBCC_OP_XORI,
        `EBCC_OP_RET, `EBCC_OP_RETURN_FROM_INTERRUPT: len = `EBCC_CYC_RMWX;
        `EBCC_OP_IO_READ_OP, `EBCC_OP_IOWR, `EBCC_OP_PUSHA, `EBCC_OP_PUSHX, `EBCC_OP_SWAX,
        `EBCC_OP_SWDSP, `EBCC_OP_STD: len = `EBCC_CYC_IO;
        `EBCC_OP_STI, `EBCC_OP_IO_WRITE_INDEXED_OP: len = `EBCC_CYC_IDX;
        default: len = `EBCC_CYC_SHORT;
      endcase
  end

  wire last = (cyc_r == (len - 4'h1));

  // alu: result, carry out and which targets update
  reg [8:0] alu;
  reg wr_a;
  reg wr_x;
  reg wr_c;
  reg wr_z;
  always @*
  begin
    alu = 9'h000;
    wr_a = 1'b0;
    wr_x = 1'b0;
    wr_c = 1'b1;
    wr_z = 1'b1;
    if (arith)
    begin
      wr_a = (grp < `EBCC_G_CMP) || (grp == `EBCC_G_MOVA);
      wr_x = (grp == `EBCC_G_MOVX);
      wr_c = (grp <= `EBCC_G_SBB) || (grp == `EBCC_G_CMP);
      wr_z = (grp <= `EBCC_G_CMP);
      case (grp)
        `EBCC_G_ADD: alu = {1'b0, a_r} + {1'b0, opnd};
        `EBCC_G_ADC: alu = {1'b0, a_r} + {1'b0, opnd} + {8'h00, c_r};
        `EBCC_G_SUB, `EBCC_G_CMP: alu = {1'b0, a_r} - {1'b0, opnd};
        `EBCC_G_SBB: alu = {1'b0, a_r} - {1'b0, opnd} - {8'h00, c_r};
        `EBCC_G_OR: alu = {1'b0, a_r | opnd};
        `EBCC_G_AND: alu = {1'b0, a_r & opnd};
        `EBCC_G_XOR: alu = {1'b0, a_r ^ opnd};
        default: alu = {1'b0, opnd};
      endcase
    end
    else
      case (dop)
        `EBCC_OP_INCA: begin alu = {1'b0, a_r} + 9'h001; wr_a = 1'b1; end
        `EBCC_OP_INCX: begin alu = {1'b0, x_r} + 9'h001; wr_x = 1'b1; end
        `EBCC_OP_DECA: begin alu = {1'b0, a_r} - 9'h001; wr_a = 1'b1; end
        `EBCC_OP_DECX: begin alu = {1'b0, x_r} - 9'h001; wr_x = 1'b1; end
        `EBCC_OP_INCD, `EBCC_OP_INCI: alu = {1'b0, mem_r} + 9'h001;
        `EBCC_OP_DECD, `EBCC_OP_DECI: alu = {1'b0, mem_r} - 9'h001;
        `EBCC_OP_ORD, `EBCC_OP_ORI: begin alu = {1'b0, mem_r | a_r}; wr_c = 1'b0; end
        `EBCC_OP_ANDD, `EBCC_OP_ANDI: begin alu = {1'b0, mem_r & a_r}; wr_c = 1'b0; end
        `EBCC_OP_XORD, `EBCC_OP_XORI: begin alu = {1'b0, mem_r ^ a_r}; wr_c = 1'b0; end
        `EBCC_OP_CPL: begin alu = {1'b0, ~a_r}; wr_a = 1'b1; wr_c = 1'b0; end
        `EBCC_OP_ASL: begin alu = {a_r, 1'b0}; wr_a = 1'b1; end
        `EBCC_OP_ASR: begin alu = {a_r[0], a_r[7], a_r[7:1]}; wr_a = 1'b1; end
        `EBCC_OP_RLC: begin alu = {a_r, c_r}; wr_a = 1'b1; end
        `EBCC_OP_RRC: begin alu = {a_r[0], c_r, a_r[7:1]}; wr_a = 1'b1; end
        `EBCC_OP_MOVAX: begin alu = {1'b0, x_r}; wr_a = 1'b1; wr_c = 1'b0; wr_z = 1'b0; end
        `EBCC_OP_MOVXA: begin alu = {1'b0, a_r}; wr_x = 1'b1; wr_c = 1'b0; wr_z = 1'b0; end
        default: begin wr_c = 1'b0; wr_z = 1'b0; end
      endcase
  end

  // ram port: stack, data stack and operand traffic share one RAM
  always @*
  begin
    ram_addr = ea;
    ram_wdata = a_r;
    ram_we = 1'b0;
    if (cyc_r == `EBCC_S_MEM)
    begin
      if (is_push)
      begin
        ram_addr = dsp_dec;
        ram_wdata = (dop == `EBCC_OP_PUSHA) ? a_r : x_r;
        ram_we = 1'b1;
      end
      else if (is_pop)
        ram_addr = dsp_r;
      else if (is_call || irq_r)
      begin
        ram_addr = psp_r;
        ram_wdata = pc_r[7:0];
        ram_we = 1'b1;
      end
    end
    else if (cyc_r == `EBCC_S_EXE)
    begin
      if (is_call || irq_r || is_ret)
      begin
        ram_addr = psp_r;
        ram_wdata = {c_r, z_r, pc_r[13:8]};
        ram_we = is_call || irq_r;
      end
      else
        ram_we = is_store;
    end
    else if (cyc_r == `EBCC_S_WB)
    begin
      if (is_ret)
        ram_addr = psp_r;
      else
      begin
        ram_wdata = res_r;
        ram_we = is_rmw;
      end
    end
  end

  assign rom_addr = ((cyc_r == `EBCC_S_MEM) && (nib == `EBCC_N_INDEX)) ? tgt_acc : pc_r;
  assign io_addr = ea;
  assign io_wdata = a_r;
  assign io_re = (cyc_r == `EBCC_S_MEM) && (dop == `EBCC_OP_IO_READ_OP) && !halt_r;
  assign io_we = (cyc_r == `EBCC_S_MEM) && !halt_r &&
    ((dop == `EBCC_OP_IOWR) || (dop == `EBCC_OP_IO_WRITE_INDEXED_OP));
  assign int_ack = (cyc_r == `EBCC_S_FETCH) && ie_r && int_req && !halt_r;
  assign int_enabled = ie_r;
  assign halted = halt_r;
  assign rom_test_area = (pc_r >= `EBCC_ROM_TEST_BASE);

  // instruction sequencer
  always @(posedge clk)
  begin
    if (rst)
    begin
      pc_r <= `EBCC_PC_RESET;
      a_r <= 8'h00;
      x_r <= 8'h00;
      psp_r <= `EBCC_PTR_RESET;
      dsp_r <= `EBCC_PTR_RESET;
      op_r <= `EBCC_OP_NOP;
      arg_r <= 8'h00;
      mem_r <= 8'h00;
      res_r <= 8'h00;
      ret_hi_r <= 8'h00;
      vec_r <= `EBCC_PC_RESET;
      cyc_r <= `EBCC_S_FETCH;
      c_r <= 1'b0;
      z_r <= 1'b0;
      ie_r <= 1'b0;
      irq_r <= 1'b0;
      halt_r <= 1'b0;
    end
    else if (!halt_r)
    begin
      cyc_r <= last ? `EBCC_S_FETCH : cyc_r + 4'h1;
      case (cyc_r)
        `EBCC_S_FETCH:
        begin
          if (int_ack)
          begin
            irq_r <= 1'b1;
            ie_r <= 1'b0;
            vec_r <= int_vector;
          end
          else
          begin
            op_r <= rom_data;
            pc_r <= {pc_r[13:8], pc_lo_inc};
          end
        end
        `EBCC_S_OPND:
        begin
          if (two_byte)
          begin
            arg_r <= rom_data;
            pc_r <= {pc_r[13:8], pc_lo_inc};
          end
        end
        `EBCC_S_MEM:
        begin
          mem_r <= ram_rdata;
          if (is_push)
            dsp_r <= dsp_dec;
          if (is_pop)
            dsp_r <= dsp_r + `EBCC_ONE;
          if (dop == `EBCC_OP_POPA)
            a_r <= ram_rdata;
          if (dop == `EBCC_OP_POPX)
            x_r <= ram_rdata;
          if (is_call || irq_r)
            psp_r <= psp_r + `EBCC_ONE;
          if (is_ret)
            psp_r <= psp_r - `EBCC_ONE;
          if (dop == `EBCC_OP_IO_READ_OP)
            a_r <= io_rdata;
          if (dop == `EBCC_OP_SWAX)
          begin
            a_r <= x_r;
            x_r <= a_r;
          end
          if (dop == `EBCC_OP_SWDSP)
          begin
            a_r <= dsp_r;
            dsp_r <= a_r;
          end
          if (dop == `EBCC_OP_MOVPSP)
            psp_r <= a_r;
          if (dop == `EBCC_OP_DI)
            ie_r <= 1'b0;
          if (dop == `EBCC_OP_EI)
            ie_r <= 1'b1;
          if (nib == `EBCC_N_INDEX)
            a_r <= rom_data;
        end
        `EBCC_S_EXE:
        begin
          res_r <= alu[7:0];
          if (wr_a)
            a_r <= alu[7:0];
          if (wr_x)
            x_r <= alu[7:0];
          if (wr_c)
            c_r <= alu[8];
          if (wr_z)
            z_r <= (alu[7:0] == 8'h00);
          if (is_call || irq_r)
            psp_r <= psp_r + `EBCC_ONE;
          if (is_ret)
          begin
            ret_hi_r <= ram_rdata;
            psp_r <= psp_r - `EBCC_ONE;
          end
        end
        `EBCC_S_WB:
        begin
          if (is_ret)
          begin
            pc_r <= {ret_hi_r[5:0], ram_rdata};
            if (dop == `EBCC_OP_RETURN_FROM_INTERRUPT)
            begin
              c_r <= ret_hi_r[7];
              z_r <= ret_hi_r[6];
            end
          end
        end
        default:
        begin
          irq_r <= irq_r;
        end
      endcase
      // end-of-instruction control transfer
      if (last)
      begin
        irq_r <= 1'b0;
        if (irq_r)
          pc_r <= vec_r;
        else if (is_call || (nib == `EBCC_N_JMP) ||
          ((nib == `EBCC_N_JZ) && z_r) || ((nib == `EBCC_N_JNZ) && !z_r) ||
          ((nib == `EBCC_N_JC) && c_r) || ((nib == `EBCC_N_JNC) && !c_r))
          pc_r <= tgt;
        else if (nib == `EBCC_N_JUMP_PLUS_ACCUMULATOR)
          pc_r <= tgt_acc;
        else if (dop == `EBCC_OP_PAGE_ADVANCE_OP)
          pc_r <= {pc_r[13:8] + 6'h01, pc_r[7:0]};
        if (dop == `EBCC_OP_RETURN_FROM_INTERRUPT)
          ie_r <= 1'b1;
        if (dop == `EBCC_OP_HALT)
          halt_r <= 1'b1;
      end
    end
  end

endmodule // ebcc_core

// *** ebcc_core_checker.sv ***
`timescale 1ns/10ps
module ebcc_core_checker (
  input wire clk,
  input wire rst,
  input wire [13:0] rom_addr,
  input wire [7:0] rom_data,
  input wire [7:0] ram_addr,
  input wire [7:0] ram_wdata,
  input wire ram_we,
  input wire [7:0] ram_rdata,
  input wire [7:0] io_addr,
  input wire [7:0] io_wdata,
  input wire io_we,
  input wire io_re,
  input wire [7:0] io_rdata,
  input wire int_req,
  input wire [13:0] int_vector,
  input wire int_ack,
  input wire int_enabled,
  input wire halted,
  input wire rom_test_area
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // first fetch after reset comes from address zero
  a_reset_fetch_zero: assert property ($fell(rst) |-> rom_addr == 14'h0000)
    else $error("first fetch not from zero");
  // top 32 program bytes flagged as reserved; a one-cycle table read is skipped
  a_test_area_flag: assert property (rom_addr >= 14'h1fe0 && $stable(rom_addr) |-> rom_test_area)
    else $error("test area flag missing");
  // acknowledge only for an enabled pending request
  a_ack_has_cause: assert property (int_ack |-> int_enabled && int_req)
    else $error("acknowledge without enabled request");
  // acknowledge turns interrupts off for the eight cycles that follow
  a_ack_masks_irq: assert property (int_ack |=> !int_enabled [*8])
    else $error("interrupts still on after acknowledge");
  // two stack bytes written at consecutive addresses
  a_irq_push_pair: assert property (int_ack |-> ##2 ram_we ##1
    (ram_we && ram_addr == $past(ram_addr) + 8'h01))
    else $error("acknowledge push pair wrong");
  // sequence ends with a fetch at the vector
  a_irq_vector_load: assert property (int_ack |-> ##10 rom_addr == $past(int_vector, 10))
    else $error("vector not fetched after acknowledge");
  // back-to-back writes are stack pushes growing upward
  a_stack_grows_up: assert property ($rose(ram_we) ##1 ram_we |->
    ram_addr == $past(ram_addr) + 8'h01)
    else $error("stack pair not ascending");
  // halt freezes every write strobe
  a_halt_stays: assert property (halted |=> halted && !ram_we && !io_we)
    else $error("activity after halt");
  // i/o write is a single strobe
  a_io_single: assert property (io_we |=> !io_we && !io_re)
    else $error("io write strobe not single");

  c_irq_taken: cover property (int_ack);
  c_halt_seen: cover property ($rose(halted));
  c_test_area: cover property (rom_test_area);
endmodule // ebcc_core_checker

bind ebcc_core ebcc_core_checker u_chk (
  .clk(clk), .rst(rst), .rom_addr(rom_addr), .rom_data(rom_data),
  .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_rdata(ram_rdata),
  .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re),
  .io_rdata(io_rdata), .int_req(int_req), .int_vector(int_vector), .int_ack(int_ack),
  .int_enabled(int_enabled), .halted(halted), .rom_test_area(rom_test_area)
);

// *** ebcc_mem_model.sv ***
`timescale 1ns/10ps
module ebcc_mem_model (
  input wire clk,
  input wire [13:0] rom_addr,
  output wire [7:0] rom_data,
  input wire [7:0] ram_addr,
  input wire [7:0] ram_wdata,
  input wire ram_we,
  output wire [7:0] ram_rdata,
  input wire [7:0] io_addr,
  input wire [7:0] io_wdata,
  input wire io_we,
  input wire io_re,
  output wire [7:0] io_rdata
);
  reg [7:0] rom [0:16383];
  reg [7:0] ram [0:255];
  reg [7:0] io [0:255];

  // combinational reads; io bus returns inverted data outside a read strobe
  assign rom_data = rom[rom_addr];
  assign ram_rdata = ram[ram_addr];
  assign io_rdata = io_re ? io[io_addr] : ~io[io_addr];

  // writes land at the rising edge
  always @(posedge clk)
  begin
    if (ram_we)
      ram[ram_addr] <= ram_wdata;
    if (io_we)
      io[io_addr] <= io_wdata;
  end
endmodule // ebcc_mem_model

// *** ebcc_core_tb.sv ***
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("wrong value %s expected %h seen %h", nm, e, g); \
    end \
  end

module ebcc_core_tb;
  logic clk = 1'b0;
  logic rst;
  logic int_req;
  logic [13:0] int_vector;
  wire [13:0] rom_addr;
  wire [7:0] rom_data, ram_addr, ram_wdata, ram_rdata, io_addr, io_wdata, io_rdata;
  wire ram_we, io_we, io_re, int_ack, int_enabled, halted, rom_test_area;
  int mismatches;
  int compares;

  ebcc_core u_dut (
    .clk(clk), .rst(rst), .rom_addr(rom_addr), .rom_data(rom_data),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_rdata(ram_rdata),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re),
    .io_rdata(io_rdata), .int_req(int_req), .int_vector(int_vector), .int_ack(int_ack),
    .int_enabled(int_enabled), .halted(halted), .rom_test_area(rom_test_area)
  );
  ebcc_mem_model u_mem (
    .clk(clk), .rom_addr(rom_addr), .rom_data(rom_data), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_rdata(ram_rdata), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re), .io_rdata(io_rdata)
  );

  // 40 MHz clock
  always #12.5 clk = ~clk;

  task automatic tally_and_finish();
    if (mismatches == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // eight program bytes, first byte at the lowest address
  task automatic put(input logic [13:0] a, input logic [63:0] v);
    for (int i = 0; i < 8; i++)
      u_mem.rom[a + i] = v[63 - 8 * i -: 8];
  endtask

  // hold reset, fill rom with nops, clear ram, fill io with ee
  task automatic clr();
    rst = 1'b1;
    int_req = 1'b0;
    for (int i = 0; i < 16384; i++)
      u_mem.rom[i] = 8'h20;
    for (int i = 0; i < 256; i++)
    begin
      u_mem.ram[i] = 8'h00;
      u_mem.io[i] = 8'hee;
    end
  endtask

  task automatic run(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic go();
    run(5);
    rst = 1'b0;
  endtask

  // immediate add timing and io write, then halt
  task automatic t_imm();
    int n;
    clr();
    put(14'h0000, 64'h1905_0103_2a10_0000);
    go();
    n = 0;
    while (io_we !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    `CHK("io write cycle", 10, n);
    `CHK("io address", 8'h10, io_addr);
    `CHK("add result", 8'h08, io_wdata);
    run(20);
    `CHK("halted", 1'b1, halted);
  endtask

  // direct, indexed with wrap, io read
  task automatic t_modes();
    clr();
    u_mem.ram[8'h12] = 8'haa;
    u_mem.ram[8'h10] = 8'hbb;
    u_mem.ram[8'h11] = 8'hcc;
    u_mem.io[8'h05] = 8'h66;
    put(14'h0000, 64'h1c02_1b10_3920_1cf0);
    put(14'h0008, 64'h1b20_2a30_1a11_2a31);
    put(14'h0010, 64'h2905_2a32_0000_0000);
    go();
    run(100);
    `CHK("indexed read", 8'haa, u_mem.io[8'h22]);
    `CHK("indexed wrap", 8'hbb, u_mem.io[8'h30]);
    `CHK("direct read", 8'hcc, u_mem.io[8'h31]);
    `CHK("io read", 8'h66, u_mem.io[8'h32]);
  endtask

  // push wraps to top, swap with pointer, pop post-increments
  task automatic t_dstack();
    clr();
    put(14'h0000, 64'h1977_2d30_2a40_3019);
    put(14'h0008, 64'h002c_402a_4130_2a42);
    put(14'h0010, 64'h0000_0000_0000_0000);
    go();
    run(100);
    `CHK("push at top", 8'h77, u_mem.ram[8'hff]);
    `CHK("pointer swap", 8'hff, u_mem.io[8'h40]);
    `CHK("pop value", 8'h77, u_mem.io[8'h41]);
    `CHK("pointer after pop", 8'h00, u_mem.io[8'h42]);
  endtask

  // two calls from one stack level with flags set
  task automatic t_call();
    clr();
    put(14'h0000, 64'h1910_6019_ff01_0190);
    put(14'h0008, 64'h2090_3000_0000_0000);
    put(14'h0020, 64'h3f00_0000_0000_0000);
    put(14'h0030, 64'h3f00_0000_0000_0000);
    go();
    run(120);
    `CHK("return low byte", 8'h0b, u_mem.ram[8'h10]);
    `CHK("flags and high", 8'hc0, u_mem.ram[8'h11]);
    `CHK("untouched above", 8'h00, u_mem.ram[8'h12]);
    `CHK("returned", 1'b1, halted);
  endtask

  // interrupt taken after enable, handler sets zero, return restores it
  task automatic t_irq();
    int n;
    clr();
    put(14'h0000, 64'h72a0_402a_6000_0000);
    put(14'h0040, 64'h2a61_0000_0000_0000);
    put(14'h0100, 64'h19ff_0101_7300_0000);
    go();
    int_req = 1'b1;
    n = 0;
    while (int_ack !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    run(1);
    int_req = 1'b0;
    `CHK("enable after ack", 1'b0, int_enabled);
    run(80);
    `CHK("enable after return", 1'b1, int_enabled);
    `CHK("zero restored", 8'h00, u_mem.io[8'h60]);
    `CHK("no zero branch", 8'hee, u_mem.io[8'h61]);
    `CHK("saved low", 8'h01, u_mem.ram[8'h00]);
    `CHK("saved flags", 8'h00, u_mem.ram[8'h01]);
  endtask

  // page advance, wrap inside page, call into test area
  task automatic t_page();
    clr();
    put(14'h0000, 64'h80fd_0000_0000_0000);
    put(14'h00fd, 64'h201f_2000_0000_0000);
    put(14'h0100, 64'h5fe0_0000_0000_0000);
    put(14'h1fe0, 64'h0000_0000_0000_0000);
    go();
    run(80);
    `CHK("page path halted", 1'b1, halted);
    `CHK("test area flag", 1'b1, rom_test_area);
  endtask

  initial
  begin
    rst = 1'b1;
    int_req = 1'b0;
    int_vector = 14'h0100;
    mismatches = 0;
    compares = 0;
    t_imm();
    t_modes();
    t_dstack();
    t_call();
    t_irq();
    t_page();
    tally_and_finish();
  end

  // hang guard
  initial
  begin
    #75000;
    mismatches++;
    tally_and_finish();
  end
endmodule // ebcc_core_tb
